// ### i2c_slave_consts.vh
// constants for the two-wire slave command and status block
// assumes a 4-bit register index and 8-bit register data
`ifndef I2C_SLAVE_CONSTS_VH
`define I2C_SLAVE_CONSTS_VH

`define OFS_MASTER_CTRL  4'h3
`define OFS_SLAVE_CTRL_A 4'h9
`define OFS_ACK_CMD_CTRL 4'ha
`define OFS_STATUS_FLAGS 4'hb
`define OFS_SLAVE_ADDR   4'hc
`define OFS_SHIFT_DATA   4'hd

`define CA_DATA_IRQ_EN   7
`define CA_ADDR_IRQ_EN   6
`define CA_STOP_DET_EN   5
`define CA_AUTO_RESUME   1
`define CA_SLAVE_EN      0

`define MC_MASTER_EN     0

`define CB_ACK_SEL       2

`define CMD_NO_OP        2'h0
`define CMD_RESERVED     2'h1
`define CMD_COMPLETE     2'h2
`define CMD_RESPONSE     2'h3

`define SF_DATA_IRQ      7
`define SF_ADDR_STOP_IRQ 6
`define SF_CONFLICT      3
`define SF_ILLEGAL       2

`define STATUS_RESET     8'h00
`define REG_RESET        8'h00
`define BITS_PER_BYTE    4'h8

`endif

// ### i2c_slave_cmd_status.v
// two-wire slave: acknowledge/command control, status flags and byte engine
// assumes scl/sda arrive asynchronous; registers reached by a plain strobe port
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_consts.vh"

module i2c_slave_cmd_status (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output wire [7:0] reg_rdata,
  input  wire       scl_in,
  output wire       scl_out,
  output wire       scl_oe,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  output wire       data_irq,
  output wire       addr_stop_irq
);

  // one-hot states; the default arm recovers from any illegal code
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_WAIT = 7'h04;
  localparam [6:0] S_ACK  = 7'h08;
  localparam [6:0] S_RX   = 7'h10;
  localparam [6:0] S_TX   = 7'h20;
  localparam [6:0] S_MACK = 7'h40;

  // what the acknowledge slot leads into
  localparam [1:0] NX_IDLE = 2'h0;
  localparam [1:0] NX_RX   = 2'h1;
  localparam [1:0] NX_DIF  = 2'h2;

  function hit;
    input [3:0] a;
    input [3:0] o;
    begin
      hit = (a == o);
    end
  endfunction

  // sda is only ever pulled low; a set collision flag forbids any low drive
  function sda_pull;
    input bit_val;
    input drive_conflict_flag;
    begin
      sda_pull = ~bit_val & ~drive_conflict_flag;
    end
  endfunction

  reg [6:0] state_r;
  reg [1:0] nx_r;
  reg [3:0] cnt_r;
  reg [7:0] sh_r;
  reg [7:0] ctrla_r;
  reg [7:0] saddr_r;
  reg       men_r;
  reg       ack_response_select_r;
  reg       ack_val_r;
  reg       kind_data_r;
  reg       addressed_r;
  reg       data_irq_flag_r;
  reg       addr_stop_irq_flag_r;
  reg       received_ack_bit_r;
  reg       drive_conflict_flag_r;
  reg       illegal_condition_flag_r;
  reg       dir_r;
  reg       addr_or_stop_cause_r;
  reg [7:0] rdata_r;
  reg       scl_oe_r;
  reg       sda_oe_r;
  reg       line_out_r;
  reg       data_irq_r;
  reg       addr_stop_irq_r;
  // two stages per pin, the third only for edge finding
  reg       scl_s1_r;
  reg       scl_s2_r;
  reg       scl_d_r;
  reg       sda_s1_r;
  reg       sda_s2_r;
  reg       sda_d_r;
  reg [7:0] rd_nxt;

  wire scl_rise   = scl_s2_r & ~scl_d_r;
  wire scl_fall   = ~scl_s2_r & scl_d_r;
  // both pins share one sync depth, so a data change under high clock stays intact
  wire start_det  = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  wire stop_det   = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
  // shift register is software-writable only while no byte is on the wire
  wire shifting   = (state_r == S_ADDR) | (state_r == S_RX) | (state_r == S_TX);
  wire wr_ctrlb   = reg_wr & hit(reg_addr, `OFS_ACK_CMD_CTRL);
  // one decode per writable register
  wire wr_master  = reg_wr & hit(reg_addr, `OFS_MASTER_CTRL);
  wire wr_ctrla   = reg_wr & hit(reg_addr, `OFS_SLAVE_CTRL_A);
  wire wr_saddr   = reg_wr & hit(reg_addr, `OFS_SLAVE_ADDR);
  wire wr_shift   = reg_wr & hit(reg_addr, `OFS_SHIFT_DATA);
  wire wr_status  = reg_wr & hit(reg_addr, `OFS_STATUS_FLAGS);
  wire cmd_valid  = wr_ctrlb & reg_wdata[1];
  wire data_acc   = (reg_wr | reg_rd) & hit(reg_addr, `OFS_SHIFT_DATA);
  wire auto_resume_mode_enable       = ctrla_r[`CA_AUTO_RESUME];
  // without auto mode only a command restarts the bus
  wire resume     = cmd_valid | (data_acc & auto_resume_mode_enable);
  wire [1:0] act_cmd = cmd_valid ? reg_wdata[1:0] : `CMD_RESPONSE;
  wire new_ack    = wr_ctrlb ? reg_wdata[`CB_ACK_SEL] : ack_response_select_r;
  // general call answers address zero when the low address bit is set
  wire addr_match = (sh_r[7:1] == saddr_r[7:1]) | (saddr_r[0] & (sh_r[7:1] == 7'h00));
  // a start or stop after the first bit of a byte breaks the protocol
  wire mid_byte   = shifting & (cnt_r != 4'h0);
  wire scl_stretch_flag = data_irq_flag_r | addr_stop_irq_flag_r;

  assign reg_rdata     = rdata_r;
  assign scl_oe        = scl_oe_r;
  assign sda_oe        = sda_oe_r;
  assign scl_out       = line_out_r;
  assign sda_out       = line_out_r;
  assign data_irq      = data_irq_r;
  assign addr_stop_irq = addr_stop_irq_r;

  always @* begin
    case (reg_addr)
      `OFS_MASTER_CTRL:  rd_nxt = {7'h00, men_r};
      `OFS_SLAVE_CTRL_A: rd_nxt = ctrla_r;
      `OFS_ACK_CMD_CTRL: rd_nxt = {5'h00, ack_response_select_r, 2'h0};
      `OFS_STATUS_FLAGS: rd_nxt = {data_irq_flag_r, addr_stop_irq_flag_r, scl_stretch_flag,
                                   received_ack_bit_r, drive_conflict_flag_r,
                                   illegal_condition_flag_r, dir_r, addr_or_stop_cause_r};
      `OFS_SLAVE_ADDR:   rd_nxt = saddr_r;
      `OFS_SHIFT_DATA:   rd_nxt = sh_r;
      default:           rd_nxt = 8'h00;
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r  <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r  <= 1'b1;
      state_r <= S_IDLE;
      nx_r <= NX_IDLE;
      cnt_r <= 4'h0;
      sh_r <= `REG_RESET;
      ctrla_r <= `REG_RESET;
      saddr_r <= `REG_RESET;
      men_r <= 1'b0;
      ack_response_select_r <= 1'b0;
      ack_val_r <= 1'b0;
      kind_data_r <= 1'b0;
      addressed_r <= 1'b0;
      data_irq_flag_r <= 1'b0;
      addr_stop_irq_flag_r <= 1'b0;
      received_ack_bit_r <= 1'b0;
      drive_conflict_flag_r <= 1'b0;
      illegal_condition_flag_r <= 1'b0;
      dir_r <= 1'b0;
      addr_or_stop_cause_r <= 1'b0;
      rdata_r <= `STATUS_RESET;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      line_out_r <= 1'b0;
      data_irq_r <= 1'b0;
      addr_stop_irq_r <= 1'b0;
    end else begin
      // third stage only feeds edge detection, never the raw pin stage
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r  <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r  <= sda_s2_r;
      line_out_r <= 1'b0;
      // read data stands one cycle only, so stale data never leaks
      rdata_r <= reg_rd ? rd_nxt : 8'h00;
      if (wr_ctrla)
        ctrla_r <= reg_wdata;
      if (wr_master)
        men_r <= reg_wdata[`MC_MASTER_EN];
      if (wr_saddr)
        saddr_r <= reg_wdata;
      if (wr_ctrlb)
        ack_response_select_r <= reg_wdata[`CB_ACK_SEL];
      if (wr_shift & ~shifting)
        sh_r <= reg_wdata;
      // only the w1c bits are touched here; read-only bits ignore writes
      if (wr_status) begin
        if (reg_wdata[`SF_DATA_IRQ])
          data_irq_flag_r <= 1'b0;
        if (reg_wdata[`SF_ADDR_STOP_IRQ])
          addr_stop_irq_flag_r <= 1'b0;
        if (reg_wdata[`SF_CONFLICT])
          drive_conflict_flag_r <= 1'b0;
        if (reg_wdata[`SF_ILLEGAL])
          illegal_condition_flag_r <= 1'b0;
      end
      if (cmd_valid | data_acc) begin
        data_irq_flag_r <= 1'b0;
        addr_stop_irq_flag_r <= 1'b0;
      end
      // one cycle of lag keeps the interrupt pins registered
      data_irq_r <= data_irq_flag_r & ctrla_r[`CA_DATA_IRQ_EN];
      addr_stop_irq_r <= addr_stop_irq_flag_r & ctrla_r[`CA_ADDR_IRQ_EN];
      // flag sets below come later in this block so a set beats a clear
      // disabling drops any hold at once, so the master is never left stretched
      if (~ctrla_r[`CA_SLAVE_EN]) begin
        state_r <= S_IDLE;
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
        addressed_r <= 1'b0;
      end else if (start_det) begin
        drive_conflict_flag_r <= 1'b0;
        if (men_r & mid_byte)
          illegal_condition_flag_r <= 1'b1;
        state_r <= S_ADDR;
        cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
        scl_oe_r <= 1'b0;
      end else if (stop_det) begin
        if (men_r & (mid_byte | ((state_r == S_ADDR) & (cnt_r == 4'h0))))
          illegal_condition_flag_r <= 1'b1;
        if (ctrla_r[`CA_STOP_DET_EN] & addressed_r) begin
          addr_stop_irq_flag_r <= 1'b1;
          addr_or_stop_cause_r <= 1'b0;
        end
        addressed_r <= 1'b0;
        state_r <= S_IDLE;
        sda_oe_r <= 1'b0;
        scl_oe_r <= 1'b0;
      end else begin
        case (state_r)
          S_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          S_ADDR: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_s2_r};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall & (cnt_r == `BITS_PER_BYTE)) begin
              if (addr_match) begin
                addr_stop_irq_flag_r <= 1'b1;
                addr_or_stop_cause_r <= 1'b1;
                dir_r <= sh_r[0];
                addressed_r <= 1'b1;
                kind_data_r <= 1'b0;
                scl_oe_r <= 1'b1;
                state_r <= S_WAIT;
              end else begin
                state_r <= S_IDLE;
              end
            end
          end
          S_WAIT: begin
            // without auto mode a data access clears flags but scl stays held
            if (resume) begin
              scl_oe_r <= 1'b0;
              ack_val_r <= new_ack;
              cnt_r <= 4'h0;
              if (act_cmd == `CMD_COMPLETE) begin
                if (~dir_r) begin
                  sda_oe_r <= sda_pull(new_ack, drive_conflict_flag_r);
                  nx_r <= NX_IDLE;
                  state_r <= S_ACK;
                end else begin
                  state_r <= S_IDLE;
                end
              end else if (~kind_data_r | ~dir_r) begin
                sda_oe_r <= sda_pull(new_ack, drive_conflict_flag_r);
                nx_r <= (~kind_data_r & dir_r) ? NX_DIF : NX_RX;
                state_r <= S_ACK;
              end else begin
                sda_oe_r <= sda_pull(sh_r[7], drive_conflict_flag_r);
                state_r <= S_TX;
              end
            end
          end
          S_ACK: begin
            // only a nack can be overridden, so only then is a conflict possible
            if (scl_rise & ack_val_r & ~sda_s2_r)
              drive_conflict_flag_r <= 1'b1;
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              case (nx_r)
                NX_RX: state_r <= S_RX;
                NX_DIF: begin
                  data_irq_flag_r <= 1'b1;
                  kind_data_r <= 1'b1;
                  scl_oe_r <= 1'b1;
                  state_r <= S_WAIT;
                end
                default: state_r <= S_IDLE;
              endcase
            end
          end
          S_RX: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_s2_r};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall & (cnt_r == `BITS_PER_BYTE)) begin
              data_irq_flag_r <= 1'b1;
              kind_data_r <= 1'b1;
              scl_oe_r <= 1'b1;
              state_r <= S_WAIT;
            end
          end
          S_TX: begin
            if (scl_rise) begin
              if (sh_r[7] & ~sda_s2_r)
                drive_conflict_flag_r <= 1'b1;
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall) begin
              // next bit goes out on the fall so it is stable before the next rise
              sh_r <= {sh_r[6:0], 1'b1};
              if (cnt_r == `BITS_PER_BYTE) begin
                sda_oe_r <= 1'b0;
                state_r <= S_MACK;
              end else begin
                sda_oe_r <= sda_pull(sh_r[6], drive_conflict_flag_r);
              end
            end
          end
          S_MACK: begin
            // master's ack lands in status before the data flag rises
            if (scl_rise)
              received_ack_bit_r <= sda_s2_r;
            else if (scl_fall) begin
              data_irq_flag_r <= 1'b1;
              scl_oe_r <= 1'b1;
              state_r <= S_WAIT;
            end
          end
          default: begin
            state_r <= S_IDLE;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ### i2c_slave_cmd_status_asserts.sv
// port-level checks for the two-wire slave command and status block
// assumes one clock domain and the active-high asynchronous rst
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_cmd_status_asserts (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       data_irq,
  input wire logic       addr_stop_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic cb_wr = reg_wr && reg_addr == 4'ha;
  wire logic cb_rd = reg_rd && reg_addr == 4'ha;
  wire logic st_rd = reg_rd && reg_addr == 4'hb;
  a_cmd_reads_zero: assert property (cb_rd |=> reg_rdata[1:0] == 2'h0)
    else $error("command field read back non-zero");
  a_ack_sel_holds: assert property (cb_wr ##1 cb_rd |=> reg_rdata[2] == $past(reg_wdata[2], 2))
    else $error("ack select not kept");
  a_stretch_mirror: assert property (st_rd |=> reg_rdata[5] == (reg_rdata[7] | reg_rdata[6]))
    else $error("stretch flag does not follow irq flags");
  a_stretch_pin: assert property (st_rd ##1 reg_rdata[7] |-> scl_oe)
    else $error("data flag set without scl held");
  a_open_drain: assert property (!scl_out && !sda_out)
    else $error("wire driven high");
  a_cmd_releases: assert property (cb_wr && reg_wdata[1] && scl_oe |=> !scl_oe)
    else $error("executing command did not release scl");
  a_noop_holds: assert property (cb_wr && !reg_wdata[1] && scl_oe |=> scl_oe)
    else $error("no-action command released scl");
  a_irq_after_hold: assert property ($rose(data_irq) |-> $past(scl_oe))
    else $error("data irq without clock hold");
endmodule
bind i2c_slave_cmd_status i2c_slave_cmd_status_asserts u_chk (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .data_irq(data_irq), .addr_stop_irq(addr_stop_irq));
`default_nettype wire

// ### i2c_master_model.sv
// behavioural two-wire bus master driving the slave's far side
// assumes the bench resolves both wires open-drain with pull-ups
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input  wire logic scl,
  input  wire logic sda,
  output var logic  scl_low,
  output var logic  sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // waits out the slave's clock stretch, bounded so a stuck hold cannot hang
  task automatic high_phase;
    int n;
    scl_low = 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 4000) begin
      #5;
      n++;
    end
    #40;
  endtask
  task automatic bit_io(input logic b, output logic s);
    #10 sda_low = !b;
    #10;
    high_phase;
    s = sda;
    scl_low = 1'b1;
    #20;
  endtask
  task automatic bits(input logic [7:0] w, output logic [7:0] r);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], s);
      r[i] = s;
    end
  endtask
  task automatic start;
    sda_low = 1'b1;
    #40 scl_low = 1'b1;
    #20;
  endtask
  task automatic stop;
    #10 sda_low = 1'b1;
    #10;
    high_phase;
    sda_low = 1'b0;
    #40;
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the two-wire slave command and status block
// assumes the master model on the far side and pull-ups on both wires
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module tb;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  wire  [7:0] reg_rdata;
  wire        scl_out, scl_oe, sda_out, sda_oe, data_irq, addr_stop_irq;
  wire        scl_low, sda_low;
  wire        scl = !(scl_low | scl_oe);
  wire        sda = !(sda_low | sda_oe);
  int         failures = 0;
  int         n_checks = 0;
  logic [7:0] d;
  logic       a;
  always #2.5 clk_sys = ~clk_sys;
  i2c_slave_cmd_status i_i2c_slave_cmd_status (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .data_irq(data_irq), .addr_stop_irq(addr_stop_irq));
  i2c_master_model m_master (.scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));
  task automatic wr(input logic [3:0] ad, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data only stands in the slot after the strobe
  task automatic rd(input logic [3:0] ad);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // write strobe then read strobe on the very next edge, no gap
  task automatic wr_rd(input logic [3:0] ad, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic st(input logic [7:0] m, input logic [7:0] e);
    rd(4'hb);
    `CHK(d & m, e)
  endtask
  task automatic t_regs;
    st(8'hff, 8'h00);
    wr_rd(4'ha, 8'h05);
    `CHK(d, 8'h04)
    wr(4'hb, 8'h33);
    st(8'hff, 8'h00);
    rd(4'hf);
    `CHK(d, 8'h00)
    wr(4'ha, 8'h00);
  endtask
  task automatic t_mwrite;
    wr(4'hc, 8'ha4);
    wr(4'h9, 8'he1);
    m_master.start();
    m_master.bits(8'ha4, d);
    st(8'hff, 8'h61);
    `CHK(addr_stop_irq, 1'b1)
    wr(4'ha, 8'h03);
    m_master.bit_io(1'b1, a);
    `CHK(a, 1'b0)
    st(8'hc0, 8'h00);
    m_master.bits(8'h3c, d);
    st(8'hfe, 8'ha0);
    `CHK(data_irq, 1'b1)
    rd(4'hd);
    `CHK(d, 8'h3c)
    st(8'h80, 8'h00);
    wr(4'ha, 8'h06);
    m_master.bit_io(1'b1, a);
    `CHK(a, 1'b1)
    m_master.stop();
    st(8'h41, 8'h40);
    wr(4'hb, 8'h40);
    st(8'h40, 8'h00);
  endtask
  task automatic t_mread;
    m_master.start();
    m_master.bits(8'ha5, d);
    st(8'h43, 8'h43);
    wr(4'ha, 8'h03);
    m_master.bit_io(1'b1, a);
    `CHK(a, 1'b0)
    st(8'ha0, 8'ha0);
    wr(4'hd, 8'h96);
    wr(4'ha, 8'h03);
    m_master.bits(8'hff, d);
    `CHK(d, 8'h96)
    m_master.bit_io(1'b1, a);
    st(8'h90, 8'h90);
    wr(4'ha, 8'h02);
    m_master.stop();
    wr(4'hb, 8'h40);
  endtask
  // auto mode: data register reads alone resume the bus
  task automatic t_auto;
    wr(4'h9, 8'he3);
    m_master.start();
    m_master.bits(8'ha4, d);
    rd(4'hd);
    m_master.bit_io(1'b1, a);
    `CHK(a, 1'b0)
    m_master.bits(8'h5a, d);
    rd(4'hd);
    `CHK(d, 8'h5a)
    m_master.bit_io(1'b1, a);
    `CHK(a, 1'b0)
    m_master.stop();
    wr(4'hb, 8'h40);
  endtask
  task automatic t_illegal_condition_flag;
    wr(4'h3, 8'h01);
    m_master.start();
    m_master.stop();
    st(8'h04, 8'h04);
    wr(4'hb, 8'h04);
    st(8'h04, 8'h00);
  endtask
  task automatic wrap_up;
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    t_mwrite;
    t_mread;
    t_auto;
    t_illegal_condition_flag;
    wrap_up;
  end
  // whole run needs about five microseconds
  initial begin
    #200000;
    failures++;
    wrap_up;
  end
endmodule
`default_nettype wire
